/* verilog/watchdog_timer.sv */
`timescale 1ns/1ps
// Overview of operation
// - watchdog counts 31 kHz ticks divided down from the system clock mclk.
// - dedicated 16-bit prescaler, ratio chosen by period_select.
// - optional shared 8-bit prescaler chosen by prescaler_assign and shared_prescale_ratio.
// - total time-out range runs from about 1 ms to 541 seconds.
// - period_select 0 gives 1:32, doubling each step to 1:65536; 12-15 reserved.
// - reset loads period_select 0100, soft enable 0 and option_settings FF (shared 1:256 assigned), about 4.2 s.
// - soft_watch_on in bit 0 turns watchdog on, resets to 0.
// - fuse_watch_on set means always running, soft bit ignored.
// - fuse clear lets the soft bit start and stop the watchdog.
// - count cleared by clear instruction, oscillator failure, or disabled watchdog.
// - wake with non-crystal clock clears the watchdog count.
// - wake with crystal clock holds count clear until start-up count ends.
// - start-up counter running holds watchdog in reset; resumes after expiry.
// - slow oscillator stable indication unaffected by watchdog use.
// - power-down entered only by the sleep instruction.
// - sleep entry clears count; watchdog keeps running asleep.
// - sleep entry clears powered_down_flag and sets timeout_flag.
// - asleep, main oscillator driver off and I/O drive state frozen.
// - watchdog reset is internal, requested on device_reset_req.
// - time-out while asleep wakes the device and clears timeout_flag.
// - every wake-up from sleep clears the watchdog count.
`include "watchdog_consts.svh"

module watchdog_timer (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire watchdog_pkg::wb_req_t wb_req,
	output watchdog_pkg::wb_rsp_t      wb_rsp,
	input  wire logic                  fuse_watch_on,
	input  wire logic                  osc_fail,
	input  wire logic                  slow_osc_ready,
	input  wire logic                  irq_wake,
	input  wire logic [7:0]            io_out_live,
	input  wire logic [7:0]            io_oe_live,
	output logic                       device_reset_req,
	output logic                       main_osc_on,
	output logic                       slow_osc_stable,
	output logic [7:0]                 io_out,
	output logic [7:0]                 io_oe,
	output logic                       asleep
);
	import watchdog_pkg::*;

	// ***************************************
	// registers
	// ***************************************
	logic [7:0]   watchdog_control;
	logic [7:0]   option_settings;
	logic         powered_down_flag;
	logic         timeout_flag;
	logic         crystal_mode;
	power_state_t pstate;
	logic [9:0]   slow_div;
	logic         slow_tick;
	logic [7:0]   shared_pre;
	logic [15:0]  wd_pre;
	logic [7:0]   wd_post;
	logic [10:0]  ost_count;
	logic         ack;
	logic         wd_pre_done;
	logic         wd_post_done;

	// ***************************************
	// bus decode
	// ***************************************
	wire        bus_req     = wb_req.cyc & wb_req.stb & ~ack;
	wire        bus_wr      = bus_req & wb_req.we & wb_req.sel[0];
	wire        wr_control  = bus_wr & (wb_req.adr == `WD_CONTROL_ADDR);
	wire        wr_option   = bus_wr & (wb_req.adr == `WD_OPTION_ADDR);
	wire        wr_sysctl   = bus_wr & (wb_req.adr == `WD_SYSCTL_ADDR);
	wire        clear_instr = wr_sysctl & wb_req.dat[`WD_CLEAR_WATCH_INSTR_BIT];
	wire        sleep_instr = wr_sysctl & wb_req.dat[`WD_SLEEP_BIT];
	wire        soft_wake   = wr_sysctl & wb_req.dat[`WD_WAKE_BIT];
	wire        crystal_wr  = wb_req.dat[`WD_CRYSTAL_BIT];
	wire [7:0]  status_view = {4'h0, pstate == ST_OST, pstate != ST_RUN, timeout_flag, powered_down_flag};
	wire [7:0]  read_mux    = (wb_req.adr == `WD_CONTROL_ADDR) ? watchdog_control :
	                          (wb_req.adr == `WD_OPTION_ADDR)  ? option_settings :
	                          (wb_req.adr == `WD_STATUS_ADDR)  ? status_view :
	                          (wb_req.adr == `WD_SYSCTL_ADDR)  ? {7'h00, crystal_mode} << `WD_CRYSTAL_BIT :
	                          8'h00;

	// ***************************************
	// enable and clear conditions
	// ***************************************
	wire        soft_watch_on = watchdog_control[`WD_SOFT_ON_BIT];
	wire [3:0]  period_select = watchdog_control[`WD_PS_MSB:`WD_PS_LSB];
	wire        prescaler_assign = option_settings[`WD_ASSIGN_BIT];
	wire [2:0]  shared_prescale_ratio = option_settings[2:0];
	wire        wd_enabled    = fuse_watch_on | soft_watch_on;
	wire        is_asleep     = (pstate == ST_ASLEEP);
	wire        in_ost        = (pstate == ST_OST);
	wire        wd_expired    = wd_enabled & ~in_ost & (wd_post_done & wd_pre_done) & slow_tick;
	wire        wake_event    = is_asleep & (irq_wake | soft_wake | wd_expired);
	wire        sleep_entry   = (pstate == ST_RUN) & sleep_instr;
	wire        wd_clear      = ~wd_enabled | clear_instr | osc_fail | sleep_entry |
	                            wake_event | in_ost | (wd_expired & ~is_asleep);

	// ***************************************
	// time-out detection
	// ***************************************
	// dedicated prescaler tap: 1:32 << period_select
	wire [4:0]  pre_bit       = (period_select > `WD_PS_MAX) ? 5'h0F : 5'(period_select) + 5'h04;
	wire [15:0] pre_mask      = 16'((17'h00002 << pre_bit) - 17'h00001);
	assign wd_pre_done = ((wd_pre & pre_mask) == pre_mask);
	wire [7:0]  post_mask     = prescaler_assign ?
	                            8'((9'h002 << shared_prescale_ratio) - 9'h001) : 8'h00;
	assign wd_post_done = ((wd_post & post_mask) == post_mask);

	// ***************************************
	// slow oscillator tick
	// ***************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			slow_div  <= 10'h000;
			slow_tick <= 1'b0;
		end else begin
			slow_tick <= (slow_div == 10'(`WD_SLOW_DIV - 1));
			slow_div  <= (slow_div == 10'(`WD_SLOW_DIV - 1)) ? 10'h000 : slow_div + 10'h001;
		end
	end

	// ***************************************
	// watchdog counters
	// ***************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			wd_pre  <= 16'h0000;
			wd_post <= 8'h00;
		end else if (wd_clear) begin
			wd_pre  <= 16'h0000;
			wd_post <= 8'h00;
		end else if (slow_tick) begin
			wd_pre  <= wd_pre + 16'h0001;
			if (wd_pre_done)
				wd_post <= wd_post + 8'h01;
		end
	end

	// shared prescaler only matters when assigned here
	always_ff @(posedge mclk) begin
		if (rst)
			shared_pre <= 8'h00;
		else
			shared_pre <= wd_post;
	end

	// ***************************************
	// registers
	// ***************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			watchdog_control <= `WD_CONTROL_RESET;
			option_settings  <= `WD_OPTION_RESET;
			crystal_mode     <= 1'b0;
		end else begin
			if (wr_control)
				watchdog_control <= wb_req.dat[7:0] & `WD_CONTROL_MASK;
			if (wr_option)
				option_settings <= wb_req.dat[7:0];
			if (wr_sysctl)
				crystal_mode <= crystal_wr;
		end
	end

	// ***************************************
	// power state
	// ***************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			pstate            <= ST_RUN;
			ost_count         <= 11'h000;
			powered_down_flag <= 1'b1;
			timeout_flag      <= 1'b1;
		end else begin
			case (pstate)
				ST_RUN: begin
					if (sleep_entry) begin
						pstate            <= ST_ASLEEP;
						powered_down_flag <= 1'b0;
						timeout_flag      <= 1'b1;
					end else if (wd_expired) begin
						timeout_flag <= 1'b0;
					end
				end
				ST_ASLEEP: begin
					if (wake_event) begin
						if (wd_expired)
							timeout_flag <= 1'b0;
						ost_count <= 11'h000;
						pstate    <= crystal_mode ? ST_OST : ST_RUN;
					end
				end
				ST_OST: begin
					ost_count <= ost_count + 11'h001;
					if (ost_count == 11'(`WD_OST_CYCLES - 1))
						pstate <= ST_RUN;
				end
				default: pstate <= ST_RUN;
			endcase
		end
	end

	// ***************************************
	// outputs
	// ***************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			device_reset_req <= 1'b0;
			main_osc_on      <= 1'b1;
			slow_osc_stable  <= 1'b0;
			io_out           <= 8'h00;
			io_oe            <= 8'h00;
			asleep           <= 1'b0;
			ack              <= 1'b0;
			wb_rsp           <= '0;
		end else begin
			device_reset_req <= wd_expired & (pstate == ST_RUN) & ~sleep_entry;
			main_osc_on      <= ~(is_asleep & ~wake_event) & ~sleep_entry;
			slow_osc_stable  <= slow_osc_ready;
			asleep           <= (is_asleep & ~wake_event) | sleep_entry;
			if (~(is_asleep | sleep_entry)) begin
				io_out <= io_out_live;
				io_oe  <= io_oe_live;
			end
			ack        <= bus_req;
			wb_rsp.ack <= bus_req;
			wb_rsp.dat <= bus_req ? {24'h000000, read_mux} : 32'h00000000;
		end
	end

	// ***************************************
	// checks
	// ***************************************
	sequence s_sleep_go;
		sleep_entry;
	endsequence

	a_sleep_flags: assert property (@(posedge mclk) disable iff (rst)
		s_sleep_go |=> (!powered_down_flag && timeout_flag && asleep))
		else $error("sleep entry flags wrong");
	a_sleep_clear: assert property (@(posedge mclk) disable iff (rst)
		s_sleep_go |=> (wd_pre == 16'h0000))
		else $error("sleep entry did not clear count");
	a_disabled_zero: assert property (@(posedge mclk) disable iff (rst)
		!wd_enabled |=> (wd_pre == 16'h0000 && wd_post == 8'h00))
		else $error("disabled watchdog not held at zero");
	a_ost_hold: assert property (@(posedge mclk) disable iff (rst)
		(in_ost && $past(in_ost)) |-> (wd_pre == 16'h0000))
		else $error("count moved during start-up");
	a_wake_timeout: assert property (@(posedge mclk) disable iff (rst)
		(is_asleep && wd_expired) |=> (!timeout_flag && !device_reset_req))
		else $error("asleep time-out handled wrong");
	a_awake_reset: assert property (@(posedge mclk) disable iff (rst)
		(pstate == ST_RUN && wd_expired && !sleep_entry) |=> (device_reset_req && !timeout_flag))
		else $error("awake time-out did not reset");
	a_osc_off: assert property (@(posedge mclk) disable iff (rst)
		(asleep && $stable(asleep)) |-> (!main_osc_on && $stable(io_out) && $stable(io_oe)))
		else $error("sleep drive state changed");
	a_clear_instr: assert property (@(posedge mclk) disable iff (rst)
		(clear_instr || osc_fail) |=> (wd_pre == 16'h0000))
		else $error("clear request ignored");
	a_reset_value: assert property (@(posedge mclk)
		rst |=> (watchdog_control == `WD_CONTROL_RESET))
		else $error("control reset value wrong");

	// ***************************************
	// further checks
	// ***************************************
	sequence s_wake_go;
		wake_event;
	endsequence

	sequence s_crystal_wake;
		wake_event && crystal_mode;
	endsequence

	sequence s_plain_wake;
		wake_event && !crystal_mode;
	endsequence

	a_ack_pulse: assert property (@(posedge mclk) disable iff (rst)
		wb_rsp.ack |=> !wb_rsp.ack)
		else $error("ack stood longer than one cycle");

	a_ack_follows: assert property (@(posedge mclk) disable iff (rst)
		(wb_req.cyc && wb_req.stb && !ack) |=> wb_rsp.ack)
		else $error("bus request not answered");

	a_idle_data: assert property (@(posedge mclk) disable iff (rst)
		!wb_rsp.ack |-> (wb_rsp.dat == 32'h00000000))
		else $error("read data outside ack");

	a_control_upper: assert property (@(posedge mclk) disable iff (rst)
		watchdog_control[7:5] == 3'h0)
		else $error("control upper bits set");

	a_soft_bit: assert property (@(posedge mclk) disable iff (rst)
		wr_control |=> (soft_watch_on == $past(wb_req.dat[`WD_SOFT_ON_BIT])))
		else $error("soft enable not written");

	a_fuse_forces: assert property (@(posedge mclk) disable iff (rst)
		fuse_watch_on |-> wd_enabled)
		else $error("fuse enable ignored");

	a_soft_stop: assert property (@(posedge mclk) disable iff (rst)
		(!fuse_watch_on && !soft_watch_on) |-> wd_clear)
		else $error("soft disable did not stop");

	a_tick_wrap: assert property (@(posedge mclk) disable iff (rst)
		(slow_div == 10'(`WD_SLOW_DIV - 1)) |=> (slow_tick && slow_div == 10'h000))
		else $error("slow tick period wrong");

	a_tick_single: assert property (@(posedge mclk) disable iff (rst)
		slow_tick |=> !slow_tick)
		else $error("slow tick too long");

	a_ratio_low: assert property (@(posedge mclk) disable iff (rst)
		(period_select == 4'h0) |-> (pre_mask == 16'h001F))
		else $error("lowest ratio wrong");

	a_ratio_top: assert property (@(posedge mclk) disable iff (rst)
		(period_select >= 4'hB) |-> (pre_mask == 16'hFFFF))
		else $error("top or reserved ratio wrong");

	a_shared_full: assert property (@(posedge mclk) disable iff (rst)
		(prescaler_assign && shared_prescale_ratio == 3'h7) |-> (post_mask == 8'hFF))
		else $error("shared full ratio wrong");

	a_shared_off: assert property (@(posedge mclk) disable iff (rst)
		!prescaler_assign |-> (post_mask == 8'h00))
		else $error("shared prescaler used while unassigned");

	a_shared_copy: assert property (@(posedge mclk) disable iff (rst)
		shared_pre == $past(wd_post))
		else $error("shared prescaler view stale");

	a_wake_clears: assert property (@(posedge mclk) disable iff (rst)
		s_wake_go |=> (wd_pre == 16'h0000 && wd_post == 8'h00))
		else $error("wake did not clear count");

	a_plain_wake: assert property (@(posedge mclk) disable iff (rst)
		s_plain_wake |=> (pstate == ST_RUN))
		else $error("plain wake did not run");

	a_crystal_wake: assert property (@(posedge mclk) disable iff (rst)
		s_crystal_wake |=> in_ost)
		else $error("crystal wake skipped start-up");

	a_ost_end: assert property (@(posedge mclk) disable iff (rst)
		(in_ost && ost_count == 11'(`WD_OST_CYCLES - 1)) |=> (pstate == ST_RUN))
		else $error("start-up count did not end");

	a_ost_quiet: assert property (@(posedge mclk) disable iff (rst)
		in_ost |-> !wd_expired)
		else $error("time-out during start-up");

	a_stable_copy: assert property (@(posedge mclk) disable iff (rst)
		slow_osc_stable == $past(slow_osc_ready))
		else $error("stable indication wrong");

	a_sleep_only: assert property (@(posedge mclk) disable iff (rst)
		$rose(asleep) |-> $past(sleep_instr))
		else $error("sleep without instruction");

	a_reset_single: assert property (@(posedge mclk) disable iff (rst)
		device_reset_req |=> !device_reset_req)
		else $error("reset request too long");

	a_asleep_noreset: assert property (@(posedge mclk) disable iff (rst)
		asleep |-> !device_reset_req)
		else $error("reset request while asleep");

	a_pd_kept: assert property (@(posedge mclk) disable iff (rst)
		(pstate == ST_RUN && wd_expired && !sleep_entry) |=> (powered_down_flag == $past(powered_down_flag)))
		else $error("awake time-out changed power-down flag");

	a_awake_osc: assert property (@(posedge mclk) disable iff (rst)
		!asleep |-> main_osc_on)
		else $error("main oscillator off while awake");

	a_disabled_quiet: assert property (@(posedge mclk) disable iff (rst)
		!wd_enabled |-> !wd_expired)
		else $error("disabled watchdog expired");

	a_expire_clears: assert property (@(posedge mclk) disable iff (rst)
		wd_expired |=> (wd_pre == 16'h0000))
		else $error("time-out did not clear count");
endmodule

/* verilog/watchdog_consts.svh */
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH

// ***************************************
// register map (byte addresses)
// ***************************************
`define WD_CONTROL_ADDR     4'h0
`define WD_OPTION_ADDR      4'h4
`define WD_STATUS_ADDR      4'h8
`define WD_SYSCTL_ADDR      4'hC

// ***************************************
// control register fields and reset values
// ***************************************
`define WD_SOFT_ON_BIT      0
`define WD_PS_LSB           1
`define WD_PS_MSB           4
`define WD_CONTROL_RESET    8'h08
`define WD_CONTROL_MASK     8'h1F
`define WD_PS_MAX           4'hB
`define WD_OPTION_RESET     8'hFF
`define WD_ASSIGN_BIT       3

// ***************************************
// status fields (1 = set)
// ***************************************
`define WD_PD_BIT           0
`define WD_TO_BIT           1
`define WD_ASLEEP_BIT       2
`define WD_OST_BIT          3
`define WD_STATUS_RESET     8'h03

// ***************************************
// system control fields
// ***************************************
`define WD_CLEAR_WATCH_INSTR_BIT       0
`define WD_SLEEP_BIT        1
`define WD_WAKE_BIT         2
`define WD_CRYSTAL_BIT      3

// ***************************************
// timing
// ***************************************
`define WD_SYS_HZ           25000000
`define WD_SLOW_HZ          31000
`define WD_SLOW_DIV         ((`WD_SYS_HZ + `WD_SLOW_HZ - 1) / `WD_SLOW_HZ)
`define WD_OST_CYCLES       1024

`endif

/* verilog/watchdog_pkg.sv */
package watchdog_pkg;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_ASLEEP,
		ST_OST
	} power_state_t;
endpackage

/* verification/watchdog_timer_with_sleep_entry_tb.sv */
`timescale 1ns/1ps
module watchdog_timer_with_sleep_entry_tb;
	import watchdog_pkg::*;
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	wb_req_t    req = '0;
	wb_rsp_t    rsp;
	logic       fuse = 1'b0;
	logic       fail = 1'b0;
	logic       slow = 1'b0;
	logic       irq = 1'b0;
	logic [7:0] live = 8'h00;
	logic       rst_req, osc_on, osc_stable, asleep;
	logic [7:0] io_out, io_oe, rd, v;
	int         errors = 0;
	int         comparisons = 0;
	int         pulses = 0;
	int         n, p;

	always #20 mclk = ~mclk;
	always @(posedge mclk) if (rst_req === 1'b1) pulses++;

	watchdog_timer u_dut (
		.mclk(mclk), .rst(rst), .wb_req(req), .wb_rsp(rsp), .fuse_watch_on(fuse),
		.osc_fail(fail), .slow_osc_ready(slow), .irq_wake(irq), .io_out_live(live),
		.io_oe_live(live), .device_reset_req(rst_req), .main_osc_on(osc_on),
		.slow_osc_stable(osc_stable), .io_out(io_out), .io_oe(io_oe), .asleep(asleep)
	);

	// ****************
	// check and report
	// ****************
	task automatic finish_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_range(input string name, input int lo, input int hi, input int got);
		comparisons++;
		if (got < lo || got > hi) begin
			errors++;
			$display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask

	// ****************
	// bus and waits
	// ****************
	task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] wd);
		int k;
		k = 0;
		req <= '{1'b1, 1'b1, we, adr, 4'hF, {24'h000000, wd}};
		do begin
			@(posedge mclk);
			k++;
		end while (rsp.ack !== 1'b1 && k < 20);
		rd = rsp.dat[7:0];
		req <= '0;
		@(posedge mclk);
		if (k >= 20) begin
			errors++;
			finish_test();
		end
	endtask

	task automatic rdchk(input string name, input logic [3:0] adr, input logic [7:0] exp);
		bus(1'b0, adr, 8'h00);
		check(name, exp, rd);
	endtask

	function automatic logic [7:0] ctl_exp(input logic [7:0] w);
		return w & 8'h1F;
	endfunction

	task automatic idle(input int c);
		repeat (c) @(posedge mclk);
	endtask

	// wake=1 waits for asleep to drop, otherwise for a reset pulse
	task automatic wait_evt(input bit wake, input int lim);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while ((wake ? asleep !== 1'b0 : rst_req !== 1'b1) && n < lim);
		if (n >= lim) begin
			errors++;
			finish_test();
		end
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		void'($urandom(90400));
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rdchk("control", 4'h0, 8'h08);
		rdchk("option", 4'h4, 8'hFF);
		rdchk("status", 4'h8, 8'h03);
		bus(1'b1, 4'h2, 8'h5A);
		rdchk("unmapped", 4'h2, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'hFF : 8'($urandom);
			bus(1'b1, 4'h0, v);
			rdchk("control", 4'h0, ctl_exp(v));
		end
		bus(1'b1, 4'h0, 8'h01);
		idle(3);
		check("slow_osc_stable", 8'h00, {7'h00, osc_stable});
		slow <= 1'b1;
		idle(3);
		check("slow_osc_stable", 8'h01, {7'h00, osc_stable});
		bus(1'b1, 4'h0, 8'h00);
		$display("test control done");
		v = 8'($urandom);
		live <= v;
		idle(2);
		check("asleep", 8'h00, {7'h00, asleep});
		bus(1'b1, 4'hC, 8'h02);
		live <= ~v;
		idle(2);
		rdchk("status", 4'h8, 8'h06);
		check("io_out", v, io_out);
		check("io_oe", v, io_oe);
		check("main_osc_on", 8'h00, {7'h00, osc_on});
		irq <= 1'b1;
		wait_evt(1'b1, 50);
		irq <= 1'b0;
		idle(2);
		rdchk("status", 4'h8, 8'h02);
		check("io_out", ~v, io_out);
		check("main_osc_on", 8'h01, {7'h00, osc_on});
		bus(1'b1, 4'hC, 8'h0A);
		irq <= 1'b1;
		wait_evt(1'b1, 50);
		irq <= 1'b0;
		rdchk("status", 4'h8, 8'h0E);
		idle(1100);
		rdchk("status", 4'h8, 8'h02);
		bus(1'b1, 4'hC, 8'h00);
		$display("test sleep done");
		bus(1'b1, 4'h4, 8'h00);
		bus(1'b1, 4'h0, 8'h01);
		wait_evt(1'b0, 30000);
		check_range("timeout_cycles", 25000, 27500, n);
		idle(2);
		rdchk("status", 4'h8, 8'h00);
		p = pulses;
		idle(13500);
		bus(1'b1, 4'hC, 8'h01);
		idle(13500);
		fail <= 1'b1;
		idle(1);
		fail <= 1'b0;
		idle(13500);
		check_range("reset_pulses", p, p, pulses);
		bus(1'b1, 4'h0, 8'h00);
		$display("test timeout done");
		fuse <= 1'b1;
		bus(1'b1, 4'hC, 8'h02);
		p = pulses;
		wait_evt(1'b1, 30000);
		check_range("sleep_timeout_cycles", 25000, 27500, n);
		check_range("reset_pulses", p, p, pulses);
		idle(2);
		rdchk("status", 4'h8, 8'h00);
		$display("test sleep timeout done");
		finish_test();
	end
endmodule
